// ===== pin_keeper_pkg.sv
// Package of constants and types for the shared bus pin keeper mux
package pin_keeper_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RST_KEEPER_EN = 1'h0;
  localparam logic RST_STRAP = 1'h0;
  localparam logic [15:0] RST_HELD_WORD = 16'h0000;
  localparam logic [7:0] RST_HELD_BYTE = 8'h00;

  // ****************************************
  // Owner of the shared pins
  // ****************************************
  typedef enum logic [2:0] {
    OWN_NONE = 3'h1,
    OWN_CORE = 3'h2,
    OWN_HOST = 3'h4
  } owner_e;

endpackage : pin_keeper_pkg

// ===== keeper_if.sv
// Interface carrying keeper control between the mux and its keepers
`timescale 1ns/1ns
interface keeper_if #(parameter int W = 16);
  logic keep_en;
  logic drive_en;
  logic [W-1:0] drive_val;
  logic [W-1:0] held_val;
  modport ctrl (output keep_en, output drive_en, output drive_val, input held_val);
  modport keep (input keep_en, input drive_en, input drive_val, output held_val);
endinterface : keeper_if

// ===== bus_keeper.sv
// Bus keeper that remembers the last level the device drove on a pin group
`timescale 1ns/1ns
module bus_keeper #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  keeper_if.keep kif
);

  logic [W-1:0] held_ff;
  logic [W-1:0] nxt_held;

  // Capture the driven level while driving, hold it otherwise
  always_comb begin
    nxt_held = held_ff;
    if (kif.drive_en) begin
      nxt_held = kif.drive_val;
    end
  end

  // Held level register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_ff <= '0;
    end else begin
      held_ff <= nxt_held;
    end
  end

  assign kif.held_val = held_ff;

endmodule : bus_keeper

// ===== strap_sync.sv
// Two-flop synchroniser for a pin level
`timescale 1ns/1ns
module strap_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Level in and out
  input wire logic din,
  output logic dout
);

  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  // Shift the pin level through two stages
  always_comb begin
    nxt_meta = din;
    nxt_sync = meta_ff;
  end

  // Synchroniser stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'h0;
      sync_ff <= 1'h0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign dout = sync_ff;

endmodule : strap_sync

// ===== shared_bus_pin_keeper_mux.sv
// Pad control for shared address, data and host byte pins with keepers
`timescale 1ns/1ns
module shared_bus_pin_keeper_mux (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Strap pins
  input wire logic wide_host_mode_strap,
  input wire logic host_port_enable_strap,
  // Bus control pins
  input wire logic hold_req,
  input wire logic out_float_n,
  // Bank switch control register bits
  input wire logic host_bus_keeper_enable,
  input wire logic data_bus_keeper_enable,
  // Core external memory side
  input wire logic [15:0] core_addr,
  input wire logic core_addr_oe,
  input wire logic [15:0] core_wdata,
  input wire logic core_data_oe,
  output logic [15:0] core_rdata,
  // Host port side inside the device
  output logic [15:0] host_addr,
  output logic [15:0] host_wdata,
  input wire logic [15:0] host_rdata,
  input wire logic host_rdata_oe,
  // Host byte pins as general I/O
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe,
  output logic [7:0] gpio_in,
  // Mode status
  output logic wide_host_mode,
  output logic host_port_enabled,
  output logic gpio_available,
  // Shared address pins
  input wire logic [15:0] shared_address_pins_i,
  output logic [15:0] shared_address_pins_o,
  output logic [15:0] shared_address_pins_oe,
  output logic [15:0] shared_address_keep,
  // Shared data pins
  input wire logic [15:0] shared_data_pins_i,
  output logic [15:0] shared_data_pins_o,
  output logic [15:0] shared_data_pins_oe,
  output logic [15:0] shared_data_keep,
  // Host byte pins
  input wire logic [7:0] host_byte_pins_i,
  output logic [7:0] host_byte_pins_o,
  output logic [7:0] host_byte_pins_oe,
  output logic [7:0] host_byte_keep
);

  // ****************************************
  // Strap sampling
  // ****************************************
  logic wide_sync;
  logic ena_sync;
  logic hold_sync;
  logic off_sync_n;
  logic released_ff;
  logic nxt_released;
  logic wide_ff;
  logic nxt_wide;
  logic ena_ff;
  logic nxt_ena;

  // Pin levels pass two flops before use
  strap_sync u_wide (.clk(clk), .rst_n(rst_n), .din(wide_host_mode_strap), .dout(wide_sync));
  strap_sync u_ena (.clk(clk), .rst_n(rst_n), .din(host_port_enable_strap), .dout(ena_sync));
  strap_sync u_hold (.clk(clk), .rst_n(rst_n), .din(hold_req), .dout(hold_sync));
  strap_sync u_off (.clk(clk), .rst_n(rst_n), .din(out_float_n), .dout(off_sync_n));

  // Straps latch once, on the third clock after reset release, then stay fixed
  logic [1:0] lat_cnt_ff;
  logic [1:0] nxt_lat_cnt;
  always_comb begin
    nxt_lat_cnt = lat_cnt_ff;
    nxt_released = released_ff;
    nxt_wide = wide_ff;
    nxt_ena = ena_ff;
    if (!released_ff) begin
      nxt_lat_cnt = lat_cnt_ff + 2'h1;
      if (lat_cnt_ff == 2'h2) begin
        nxt_released = 1'h1;
        nxt_wide = wide_sync;
        nxt_ena = ena_sync;
      end
    end
  end

  // Strap latches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_cnt_ff <= 2'h0;
      released_ff <= 1'h0;
      wide_ff <= pin_keeper_pkg::RST_STRAP;
      ena_ff <= pin_keeper_pkg::RST_STRAP;
    end else begin
      lat_cnt_ff <= nxt_lat_cnt;
      released_ff <= nxt_released;
      wide_ff <= nxt_wide;
      ena_ff <= nxt_ena;
    end
  end

  // ****************************************
  // Keepers
  // ****************************************
  keeper_if #(.W(16)) a_kif ();
  keeper_if #(.W(16)) d_kif ();
  keeper_if #(.W(8)) b_kif ();

  bus_keeper #(.W(16)) u_akeep (.clk(clk), .rst_n(rst_n), .kif(a_kif.keep));
  bus_keeper #(.W(16)) u_dkeep (.clk(clk), .rst_n(rst_n), .kif(d_kif.keep));
  bus_keeper #(.W(8)) u_bkeep (.clk(clk), .rst_n(rst_n), .kif(b_kif.keep));

  // ****************************************
  // Next pin state
  // ****************************************
  logic host_wide;
  logic a_drv;
  logic d_drv;
  logic gpio_ok;
  logic [7:0] b_oe;
  logic [7:0] b_out;

  // Ownership and drive decisions
  always_comb begin
    host_wide = released_ff & ena_ff & wide_ff;
    gpio_ok = released_ff & (~ena_ff | wide_ff);
    a_drv = released_ff & core_addr_oe & ~host_wide & ~hold_sync & off_sync_n;
    d_drv = released_ff & ~hold_sync & off_sync_n
            & (host_wide ? host_rdata_oe : core_data_oe);
    b_oe = (gpio_ok & off_sync_n) ? gpio_oe : 8'h00;
    b_out = gpio_out;
  end

  // Keeper controls, forced off until straps are latched
  always_comb begin
    a_kif.keep_en = released_ff & host_bus_keeper_enable;
    d_kif.keep_en = released_ff & data_bus_keeper_enable;
    b_kif.keep_en = released_ff & (wide_ff | host_bus_keeper_enable);
    a_kif.drive_en = a_drv;
    a_kif.drive_val = core_addr;
    d_kif.drive_en = d_drv;
    d_kif.drive_val = host_wide ? host_rdata : core_wdata;
    b_kif.drive_en = |b_oe;
    b_kif.drive_val = (b_out & b_oe) | (b_kif.held_val & ~b_oe);
  end

  // ****************************************
  // Output registers
  // ****************************************
  logic [15:0] a_o_ff, a_oe_ff, a_k_ff, d_o_ff, d_oe_ff, d_k_ff;
  logic [7:0] b_o_ff, b_oe_ff, b_k_ff, gin_ff;
  logic [15:0] haddr_ff, hwdata_ff, crdata_ff;
  logic wide_o_ff, ena_o_ff, gpio_o_ff;
  logic [15:0] a_i_sync, d_i_sync;
  logic [7:0] b_i_sync;
  logic [15:0] a_i_meta, d_i_meta;
  logic [7:0] b_i_meta;

  // Pin input synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_i_meta <= 16'h0000;
      d_i_meta <= 16'h0000;
      b_i_meta <= 8'h00;
      a_i_sync <= 16'h0000;
      d_i_sync <= 16'h0000;
      b_i_sync <= 8'h00;
    end else begin
      a_i_meta <= shared_address_pins_i;
      d_i_meta <= shared_data_pins_i;
      b_i_meta <= host_byte_pins_i;
      a_i_sync <= a_i_meta;
      d_i_sync <= d_i_meta;
      b_i_sync <= b_i_meta;
    end
  end

  // Register every pad control and user output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_o_ff <= 16'h0000;
      a_oe_ff <= 16'h0000;
      a_k_ff <= 16'h0000;
      d_o_ff <= 16'h0000;
      d_oe_ff <= 16'h0000;
      d_k_ff <= 16'h0000;
      b_o_ff <= 8'h00;
      b_oe_ff <= 8'h00;
      b_k_ff <= 8'h00;
      gin_ff <= 8'h00;
      haddr_ff <= 16'h0000;
      hwdata_ff <= 16'h0000;
      crdata_ff <= 16'h0000;
      wide_o_ff <= 1'h0;
      ena_o_ff <= 1'h0;
      gpio_o_ff <= 1'h0;
    end else begin
      // Keeper presents the remembered level when the pin is undriven
      a_o_ff <= a_drv ? core_addr : a_kif.held_val;
      a_oe_ff <= {16{a_drv}};
      a_k_ff <= {16{a_kif.keep_en}};
      d_o_ff <= d_drv ? d_kif.drive_val : d_kif.held_val;
      d_oe_ff <= {16{d_drv}};
      d_k_ff <= {16{d_kif.keep_en}};
      b_o_ff <= b_kif.drive_val;
      b_oe_ff <= b_oe;
      b_k_ff <= {8{b_kif.keep_en}};
      gin_ff <= b_i_sync;
      haddr_ff <= host_wide ? a_i_sync : 16'h0000;
      hwdata_ff <= host_wide ? d_i_sync : 16'h0000;
      crdata_ff <= host_wide ? 16'h0000 : d_i_sync;
      wide_o_ff <= host_wide;
      ena_o_ff <= released_ff & ena_ff;
      gpio_o_ff <= gpio_ok;
    end
  end

  assign shared_address_pins_o = a_o_ff;
  assign shared_address_pins_oe = a_oe_ff;
  assign shared_address_keep = a_k_ff;
  assign shared_data_pins_o = d_o_ff;
  assign shared_data_pins_oe = d_oe_ff;
  assign shared_data_keep = d_k_ff;
  assign host_byte_pins_o = b_o_ff;
  assign host_byte_pins_oe = b_oe_ff;
  assign host_byte_keep = b_k_ff;
  assign gpio_in = gin_ff;
  assign host_addr = haddr_ff;
  assign host_wdata = hwdata_ff;
  assign core_rdata = crdata_ff;
  assign wide_host_mode = wide_o_ff;
  assign host_port_enabled = ena_o_ff;
  assign gpio_available = gpio_o_ff;

endmodule : shared_bus_pin_keeper_mux

// ===== shared_bus_pin_keeper_mux_asserts.sv
// Checker of pad control relations for the pin keeper mux
`timescale 1ns/1ns
module shared_bus_pin_keeper_mux_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Watched inputs
  input wire logic hold_req,
  input wire logic out_float_n,
  input wire logic host_bus_keeper_enable,
  input wire logic data_bus_keeper_enable,
  input wire logic wide_host_mode_strap,
  input wire logic core_data_oe,
  input wire logic host_rdata_oe,
  // Watched outputs
  input wire logic wide_host_mode,
  input wire logic host_port_enabled,
  input wire logic gpio_available,
  input wire logic [15:0] shared_address_pins_oe,
  input wire logic [15:0] shared_address_keep,
  input wire logic [15:0] shared_data_pins_oe,
  input wire logic [15:0] shared_data_keep,
  input wire logic [7:0] host_byte_pins_oe,
  input wire logic [7:0] host_byte_keep
);
  logic [3:0] up_ff;
  logic [3:0] nxt_up;
  // Cycles since reset release, saturating so straps have settled
  always_comb begin
    nxt_up = (up_ff == 4'hf) ? up_ff : up_ff + 4'h1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_ff <= 4'h0;
    end else begin
      up_ff <= nxt_up;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  keep_rst_off_a: assert property ($rose(rst_n) |-> shared_address_keep == 16'h0
    && shared_data_keep == 16'h0 && host_byte_keep == 8'h0) else $error("keeper on at reset");
  hold_float_a: assert property (hold_req [*5] |-> shared_data_pins_oe == 16'h0)
    else $error("data driven in hold");
  off_float_a: assert property (!out_float_n [*5] |-> shared_data_pins_oe == 16'h0
    && host_byte_pins_oe == 8'h0) else $error("pins driven in float");
  idle_float_a: assert property ((!core_data_oe && !host_rdata_oe) [*3]
    |-> shared_data_pins_oe == 16'h0) else $error("data driven when idle");
  dkeep_follow_a: assert property ((up_ff == 4'hf && $stable(data_bus_keeper_enable)) [*3]
    |-> shared_data_keep == {16{data_bus_keeper_enable}}) else $error("data keeper wrong");
  akeep_follow_a: assert property ((up_ff == 4'hf && $stable(host_bus_keeper_enable)) [*3]
    |-> shared_address_keep == {16{host_bus_keeper_enable}}) else $error("addr keeper wrong");
  bkeep_narrow_a: assert property ((up_ff == 4'hf && !wide_host_mode_strap
    && $stable(host_bus_keeper_enable)) [*3] |-> host_byte_keep == {8{host_bus_keeper_enable}})
    else $error("byte keeper wrong");
  bkeep_wide_a: assert property (up_ff == 4'hf && wide_host_mode |-> host_byte_keep == 8'hff)
    else $error("byte keeper off in wide mode");
  addr_wide_a: assert property (up_ff == 4'hf && wide_host_mode
    |-> shared_address_pins_oe == 16'h0) else $error("address driven in wide mode");
  gpio_mode_a: assert property (up_ff == 4'hf
    |-> gpio_available == (!host_port_enabled || wide_host_mode)) else $error("gpio mode wrong");
endmodule : shared_bus_pin_keeper_mux_asserts
bind shared_bus_pin_keeper_mux shared_bus_pin_keeper_mux_asserts u_asserts (.*);

// ===== far_pad_model.sv
// Model of the far side party on one group of pads
`timescale 1ns/1ns
module far_pad_model #(
  parameter int W = 16
) (
  // Pad side of the device
  input wire logic [W-1:0] pad_o,
  input wire logic [W-1:0] pad_oe,
  input wire logic [W-1:0] pad_keep,
  // Far side drive
  input wire logic ext_en,
  input wire logic [W-1:0] ext_val,
  // Resolved level
  output logic [W-1:0] pad_i
);
  // Device wins, then far side, then keeper; a floating pin flips
  always_comb begin
    for (int b = 0; b < W; b++) begin
      if (pad_oe[b]) begin
        pad_i[b] = pad_o[b];
      end else if (ext_en) begin
        pad_i[b] = ext_val[b];
      end else if (pad_keep[b]) begin
        pad_i[b] = pad_o[b];
      end else begin
        pad_i[b] = ~pad_o[b];
      end
    end
  end
endmodule : far_pad_model

// ===== tb_shared_bus_pin_keeper_mux.sv
// Testbench of the shared bus pin keeper mux
`timescale 1ns/1ns
module tb_shared_bus_pin_keeper_mux;
  logic clk, rst_n, wide_host_mode_strap, host_port_enable_strap, hold_req, out_float_n;
  logic host_bus_keeper_enable, data_bus_keeper_enable, core_addr_oe, core_data_oe;
  logic host_rdata_oe, wide_host_mode, host_port_enabled, gpio_available, ea, ed, eb;
  logic [15:0] core_addr, core_wdata, core_rdata, host_addr, host_wdata, host_rdata, xa, xd, w;
  logic [15:0] shared_address_pins_i, shared_address_pins_o, shared_address_pins_oe;
  logic [15:0] shared_address_keep, shared_data_pins_i, shared_data_pins_o;
  logic [15:0] shared_data_pins_oe, shared_data_keep;
  logic [7:0] gpio_out, gpio_oe, gpio_in, host_byte_pins_i, host_byte_pins_o, xb;
  logic [7:0] host_byte_pins_oe, host_byte_keep;
  string name_q[$];
  logic [15:0] exp_q[$];
  event chk_ev;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  shared_bus_pin_keeper_mux dut (.*);
  far_pad_model #(.W(16)) u_a (.pad_o(shared_address_pins_o), .pad_oe(shared_address_pins_oe),
    .pad_keep(shared_address_keep), .ext_en(ea), .ext_val(xa), .pad_i(shared_address_pins_i));
  far_pad_model #(.W(16)) u_d (.pad_o(shared_data_pins_o), .pad_oe(shared_data_pins_oe),
    .pad_keep(shared_data_keep), .ext_en(ed), .ext_val(xd), .pad_i(shared_data_pins_i));
  far_pad_model #(.W(8)) u_b (.pad_o(host_byte_pins_o), .pad_oe(host_byte_pins_oe),
    .pad_keep(host_byte_keep), .ext_en(eb), .ext_val(xb), .pad_i(host_byte_pins_i));
  // Clock and cycle ceiling
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1500) begin
      fail_count++;
      give_verdict();
    end
  end
  function automatic logic [15:0] seen(input string s);
    case (s)
      "d_oe": seen = shared_data_pins_oe;
      "d_o": seen = shared_data_pins_o;
      "d_keep": seen = shared_data_keep;
      "a_o": seen = shared_address_pins_o;
      "a_oe": seen = shared_address_pins_oe;
      "c_rdata": seen = core_rdata;
      "a_keep": seen = shared_address_keep;
      "h_addr": seen = host_addr;
      "h_wdata": seen = host_wdata;
      "b_o": seen = {8'h00, host_byte_pins_o};
      "b_oe": seen = {8'h00, host_byte_pins_oe};
      "b_keep": seen = {8'h00, host_byte_keep};
      "g_in": seen = {8'h00, gpio_in};
      default: seen = {13'h0000, wide_host_mode, host_port_enabled, gpio_available};
    endcase
  endfunction : seen
  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic note(input string nm, input logic [15:0] exp);
    name_q.push_back(nm);
    exp_q.push_back(exp);
    -> chk_ev;
    // Hold stimulus until the monitor has compared every note
    wait (name_q.size() == 0);
  endtask : note
  // Monitor takes the oldest note and compares it with the outputs
  always @(chk_ev) begin
    while (name_q.size() > 0) begin
      check(name_q[0], seen(name_q[0]), exp_q[0]);
      void'(name_q.pop_front());
      void'(exp_q.pop_front());
    end
  end
  task automatic settle;
    repeat (6) @(negedge clk);
  endtask : settle
  task automatic do_reset(input logic wide, input logic en);
    rst_n = 1'b0;
    wide_host_mode_strap = wide;
    host_port_enable_strap = en;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask : do_reset
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  // Main sequence over the three strap settings
  initial begin
    {clk, rst_n, wide_host_mode_strap, host_port_enable_strap, hold_req, core_addr_oe} = 6'h00;
    {host_bus_keeper_enable, core_data_oe, host_rdata_oe, ea, ed, eb} = 6'h00;
    {core_addr, core_wdata, host_rdata, xa, xd, gpio_out, gpio_oe, xb} = 104'h0;
    out_float_n = 1'b1;
    data_bus_keeper_enable = 1'b1;
    w = 16'($urandom(32'h31825762));
    do_reset(1'b0, 1'b1);
    note("mode", 16'h0002);
    core_addr = 16'($urandom());
    xd = 16'($urandom());
    {core_addr_oe, ed} = 2'h3;
    settle();
    note("a_o", core_addr);
    note("a_oe", 16'hffff);
    note("c_rdata", xd);
    note("h_wdata", 16'h0000);
    {core_addr_oe, ed} = 2'h0;
    w = 16'($urandom());
    core_wdata = w;
    core_data_oe = 1'b1;
    settle();
    note("d_oe", 16'hffff);
    note("d_o", w);
    note("a_oe", 16'h0000);
    note("a_o", core_addr);
    core_data_oe = 1'b0;
    settle();
    note("d_oe", 16'h0000);
    note("d_o", w);
    note("d_keep", 16'hffff);
    core_data_oe = 1'b1;
    hold_req = 1'b1;
    settle();
    note("d_oe", 16'h0000);
    hold_req = 1'b0;
    out_float_n = 1'b0;
    settle();
    note("d_oe", 16'h0000);
    out_float_n = 1'b1;
    core_data_oe = 1'b0;
    do_reset(1'b1, 1'b1);
    note("mode", 16'h0007);
    note("b_keep", 16'h00ff);
    {ea, ed, gpio_oe} = 10'h3ff;
    core_addr_oe = 1'b1;
    xa = 16'($urandom());
    xd = 16'($urandom());
    gpio_out = 8'($urandom());
    settle();
    note("h_addr", xa);
    note("h_wdata", xd);
    note("b_o", {8'h00, gpio_out});
    note("b_oe", 16'h00ff);
    note("a_oe", 16'h0000);
    out_float_n = 1'b0;
    settle();
    note("b_oe", 16'h0000);
    {out_float_n, ed, gpio_oe, eb, host_rdata_oe} = 12'h803;
    host_rdata = 16'($urandom());
    xb = 8'($urandom());
    settle();
    note("d_o", host_rdata);
    note("d_oe", 16'hffff);
    note("g_in", {8'h00, xb});
    {host_rdata_oe, eb} = 2'h0;
    do_reset(1'b0, 1'b0);
    note("mode", 16'h0001);
    host_bus_keeper_enable = 1'b1;
    data_bus_keeper_enable = 1'b0;
    settle();
    note("b_keep", 16'h00ff);
    note("a_keep", 16'hffff);
    note("d_keep", 16'h0000);
    give_verdict();
  end
endmodule : tb_shared_bus_pin_keeper_mux
